// >>> ssp_scan_control.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: a nonzero burst count stops scanning after that many scans, zero runs until software stops it.
// R2: the burst count is a full 32-bit unsigned value.
// R3: pacing source 0 uses the internal crystal tick, 2 uses the external pacing pin.
// R4: every other pacing source code is reserved and launches no scans.
// R5: in external pacing each rising pin edge bumps a counter and a scan launches when it reaches the divider.
// R6: the divider register holds the number of pin edges per scan.
// R7: the edge counter clears after each launch so every scan waits for the full count.
// R8: trigger select 0 starts scanning as soon as the stream is enabled.
// R9: trigger codes 2000-2003, 2006 and 2007 wait for an edge from the matching edge_function_unit.
// R10: the edge polarity is the unit's own choice, so its edge report is taken as given.
// R11: software configures the chosen edge_function_unit and the trigger select before enabling.
// R12: a nonzero trigger select holds off only the first scan, not each later one.
module ssp_scan_control
	import ssp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic regWrite,
	input wire logic [31:0] regWdata,
	input wire logic regRead,
	output logic [31:0] regRdata,
	output logic regRdValid,
	// stream control
	input wire logic streamEnable,
	input wire logic internalPaceTick,
	// pins and edge units
	input wire logic external_pacing_input_pin,
	input wire logic [7:0] edge_function_unit_edge,
	// status
	output logic scanLaunch,
	output logic streamArmed,
	output logic streamScanning,
	output logic burstFinished,
	output logic [31:0] scansDone
);

	ssp_ctl_type st_r;
	ssp_ctl_type st_nxt;
	logic [1:0] rstSync_r;
	logic rstN;
	logic extPulse;
	logic paceTick;
	logic trigFire;
	logic trigLegal;
	logic [31:0] trigOffset;
	logic [31:0] doneInc;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	// only the reset synchroniser runs on the raw pin; it releases two edges late
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end

	// kept apart from the state struct because it alone resets on the raw pin
	assign rstN = rstSync_r[1];

	// ------------------------------------------------------------
	// external pacing divider
	// ------------------------------------------------------------
	// the divider is held clear outside the scanning phase so a stale partial
	// count from an earlier stream cannot shorten the first scan period
	ssp_edge_divider u_divider (
		.clk(clk),
		.rstN(rstN),
		.enable(st_r.phase == SSP_SCANNING && st_r.regs.pacingSrc == SSP_SRC_EXTERNAL), // R5
		.divisor(st_r.regs.edgesPerScan), // R6
		.pinLevel(external_pacing_input_pin),
		.scanPulse(extPulse)
	);

	// ------------------------------------------------------------
	// pacing and trigger decode
	// ------------------------------------------------------------
	always_comb begin
		unique case (st_r.regs.pacingSrc)
			SSP_SRC_INTERNAL: paceTick = internalPaceTick; // R3
			SSP_SRC_EXTERNAL: paceTick = extPulse; // R3
			default: paceTick = 1'b0; // R4
		endcase
	end

	// unknown nonzero codes are legal to write but never fire, so the stream
	// simply stays armed until software disables it
	always_comb begin
		trigOffset = st_r.regs.triggerSel - SSP_TRIG_UNIT_BASE;
		trigLegal = (st_r.regs.triggerSel >= SSP_TRIG_UNIT_BASE) && (trigOffset < SSP_TRIG_UNIT_SPAN)
			&& SSP_TRIG_UNIT_MASK[trigOffset[2:0]]; // R9
		trigFire = trigLegal && edge_function_unit_edge[trigOffset[2:0]]; // R9 R10
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.scanLaunch = 1'b0;
		st_nxt.rdValid = 1'b0;
		doneInc = st_r.scansDone + SSP_ONE;

		// register writes; unmapped addresses are ignored
		if (regWrite) begin
			unique case (regAddr)
				SSP_ADDR_PACING_SRC: st_nxt.regs.pacingSrc = regWdata;
				SSP_ADDR_BURST_COUNT: st_nxt.regs.burstCount = regWdata; // R2
				SSP_ADDR_EDGES_PER_SCAN: st_nxt.regs.edgesPerScan = regWdata; // R6
				SSP_ADDR_TRIGGER_SEL: st_nxt.regs.triggerSel = regWdata;
				default: ;
			endcase
		end

		// register reads answer one cycle later; unmapped addresses read zero
		if (regRead) begin
			st_nxt.rdValid = 1'b1;
			unique case (regAddr)
				SSP_ADDR_PACING_SRC: st_nxt.rdData = st_r.regs.pacingSrc;
				SSP_ADDR_BURST_COUNT: st_nxt.rdData = st_r.regs.burstCount;
				SSP_ADDR_EDGES_PER_SCAN: st_nxt.rdData = st_r.regs.edgesPerScan;
				SSP_ADDR_TRIGGER_SEL: st_nxt.rdData = st_r.regs.triggerSel;
				default: st_nxt.rdData = 32'h0000_0000;
			endcase
		end

		// stream sequence
		unique case (st_r.phase)
			SSP_IDLE: begin
				if (streamEnable) begin
					st_nxt.scansDone = 32'h0000_0000;
					if (st_r.regs.triggerSel == SSP_TRIG_NONE) begin
						st_nxt.phase = SSP_SCANNING; // R8
					end else begin
						st_nxt.phase = SSP_ARMED; // R12 R11
					end
				end
			end
			SSP_ARMED: begin
				if (!streamEnable) begin
					st_nxt.phase = SSP_IDLE;
				end else if (trigFire) begin
					st_nxt.phase = SSP_SCANNING; // R9 R12
				end
			end
			SSP_SCANNING: begin
				// once running the trigger is no longer looked at
				if (!streamEnable) begin
					st_nxt.phase = SSP_IDLE; // R1
				end else if (paceTick) begin
					st_nxt.scanLaunch = 1'b1;
					st_nxt.scansDone = doneInc; // R2
					if (st_r.regs.burstCount != SSP_BURST_CONTINUOUS && doneInc == st_r.regs.burstCount) begin
						st_nxt.phase = SSP_FINISHED; // R1
					end
				end
			end
			SSP_FINISHED: begin
				// waits for software to drop enable so a burst never restarts by itself
				if (!streamEnable) begin
					st_nxt.phase = SSP_IDLE;
				end
			end
		endcase

		// status levels follow the next phase so the outputs come straight off flops
		st_nxt.armedFlag = (st_nxt.phase == SSP_ARMED);
		st_nxt.scanningFlag = (st_nxt.phase == SSP_SCANNING);
		st_nxt.finishedFlag = (st_nxt.phase == SSP_FINISHED);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			st_r <= '{regs: '{SSP_RST_PACING_SRC, SSP_RST_BURST_COUNT, SSP_RST_EDGES_PER_SCAN, SSP_RST_TRIGGER_SEL},
				phase: SSP_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ------------------------------------------------------------
	assign regRdata = st_r.rdData;
	assign regRdValid = st_r.rdValid;
	assign scanLaunch = st_r.scanLaunch;
	assign streamArmed = st_r.armedFlag;
	assign streamScanning = st_r.scanningFlag;
	assign burstFinished = st_r.finishedFlag;
	assign scansDone = st_r.scansDone;

endmodule : ssp_scan_control

`default_nettype wire

// >>> ssp_pkg.sv
`default_nettype none

package ssp_pkg;

	// ----------------------------------------------------------------
	// register map (word addresses on the register port)
	// ----------------------------------------------------------------
	localparam logic [15:0] SSP_ADDR_PACING_SRC = 16'h0FAE;
	localparam logic [15:0] SSP_ADDR_BURST_COUNT = 16'h0FB4;
	localparam logic [15:0] SSP_ADDR_EDGES_PER_SCAN = 16'h0FB6;
	localparam logic [15:0] SSP_ADDR_TRIGGER_SEL = 16'h0FB8;

	// reset values
	localparam logic [31:0] SSP_RST_PACING_SRC = 32'h0000_0000;
	localparam logic [31:0] SSP_RST_BURST_COUNT = 32'h0000_0000;
	localparam logic [31:0] SSP_RST_EDGES_PER_SCAN = 32'h0000_0001;
	localparam logic [31:0] SSP_RST_TRIGGER_SEL = 32'h0000_0000;

	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam logic [31:0] SSP_SRC_INTERNAL = 32'h0000_0000;
	localparam logic [31:0] SSP_SRC_EXTERNAL = 32'h0000_0002;
	localparam logic [31:0] SSP_BURST_CONTINUOUS = 32'h0000_0000;
	localparam logic [31:0] SSP_TRIG_NONE = 32'h0000_0000;
	localparam logic [31:0] SSP_TRIG_UNIT_BASE = 32'h0000_07D0;
	localparam logic [31:0] SSP_TRIG_UNIT_SPAN = 32'h0000_0008;
	// units 0..3, 6 and 7 may start a stream
	localparam logic [7:0] SSP_TRIG_UNIT_MASK = 8'hCF;
	localparam logic [31:0] SSP_ONE = 32'h0000_0001;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SSP_IDLE = 2'h0,
		SSP_ARMED = 2'h1,
		SSP_SCANNING = 2'h3,
		SSP_FINISHED = 2'h2
	} ssp_phase_type;

	typedef struct packed {
		logic [31:0] pacingSrc;
		logic [31:0] burstCount;
		logic [31:0] edgesPerScan;
		logic [31:0] triggerSel;
	} ssp_regs_type;

	typedef struct packed {
		ssp_regs_type regs;
		ssp_phase_type phase;
		logic [31:0] scansDone;
		logic scanLaunch;
		logic [31:0] rdData;
		logic rdValid;
		logic armedFlag;
		logic scanningFlag;
		logic finishedFlag;
	} ssp_ctl_type;

	typedef struct packed {
		logic pinPrev;
		logic [31:0] edgeCount;
		logic scanPulse;
	} ssp_div_type;

endpackage : ssp_pkg

`default_nettype wire

// >>> ssp_edge_divider.sv
`timescale 1ns/1ps
`default_nettype none

// counts rising edges on the external pacing pin and pulses once per divisor edges
module ssp_edge_divider
	import ssp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// control
	input wire logic enable,
	input wire logic [31:0] divisor,
	// pin and result
	input wire logic pinLevel,
	output logic scanPulse
);

	ssp_div_type st_r;
	ssp_div_type st_nxt;
	logic [31:0] needed;
	logic [31:0] countInc;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// a divisor of zero is treated as one, so every rising edge fires
	always_comb begin
		needed = (divisor == 32'h0000_0000) ? SSP_ONE : divisor;
		countInc = st_r.edgeCount + SSP_ONE;
		st_nxt = st_r;
		st_nxt.pinPrev = pinLevel;
		st_nxt.scanPulse = 1'b0;
		if (!enable) begin
			st_nxt.edgeCount = 32'h0000_0000;
		end else if (pinLevel && !st_r.pinPrev) begin
			if (countInc >= needed) begin // R5 R6
				st_nxt.scanPulse = 1'b1;
				st_nxt.edgeCount = 32'h0000_0000; // R7
			end else begin
				st_nxt.edgeCount = countInc; // R5
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign scanPulse = st_r.scanPulse;

endmodule : ssp_edge_divider

`default_nettype wire

// >>> ssp_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// stream checker
// ----------------
module ssp_checker
	import ssp_pkg::*;
(
	// clock, reset, registers
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] regAddr,
	input wire logic regWrite,
	input wire logic [31:0] regWdata,
	// stream
	input wire logic streamEnable,
	input wire logic internalPaceTick,
	input wire logic [7:0] edge_function_unit_edge,
	input wire logic scanLaunch,
	input wire logic streamArmed,
	input wire logic streamScanning,
	input wire logic burstFinished,
	input wire logic [31:0] scansDone
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [31:0] srcR, burstR, trigR, unitIdx;
	logic trigHit, idle;

	// shadow copies, updated on the same edge as the live registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			srcR <= SSP_RST_PACING_SRC;
			burstR <= SSP_RST_BURST_COUNT;
			trigR <= SSP_RST_TRIGGER_SEL;
		end else if (regWrite) begin
			if (regAddr == SSP_ADDR_PACING_SRC) srcR <= regWdata;
			if (regAddr == SSP_ADDR_BURST_COUNT) burstR <= regWdata;
			if (regAddr == SSP_ADDR_TRIGGER_SEL) trigR <= regWdata;
		end
	end

	// selected unit fires; codes outside the mask never hit
	assign unitIdx = trigR - SSP_TRIG_UNIT_BASE;
	assign trigHit = unitIdx < 32'h8 && SSP_TRIG_UNIT_MASK[unitIdx[2:0]] && edge_function_unit_edge[unitIdx[2:0]];
	assign idle = !streamArmed && !streamScanning && !burstFinished;

	a_enable_stop: assert property (!streamEnable |=> idle)
		else $error("stream kept running");
	a_trig_none: assert property (streamEnable && idle && trigR == SSP_TRIG_NONE |=> streamScanning)
		else $error("untriggered start missing");
	a_trig_fire: assert property (streamEnable && streamArmed && trigHit |=> streamScanning && !streamArmed)
		else $error("trigger ignored");
	a_trig_hold: assert property (streamEnable && streamArmed && !trigHit |=> streamArmed)
		else $error("left armed without trigger");
	a_armed_quiet: assert property (streamArmed |=> !scanLaunch)
		else $error("launch while armed");
	a_tick_launch: assert property (streamEnable && streamScanning && internalPaceTick
		&& srcR == SSP_SRC_INTERNAL |=> scanLaunch)
		else $error("tick did not launch");
	a_reserved_quiet: assert property (srcR != SSP_SRC_INTERNAL && srcR != SSP_SRC_EXTERNAL |=> !scanLaunch)
		else $error("reserved source launched");
	a_count_step: assert property (scanLaunch |-> scansDone == $past(scansDone) + SSP_ONE)
		else $error("scan count step wrong");
	a_burst_stop: assert property ($rose(burstFinished) |-> scanLaunch && scansDone == burstR)
		else $error("burst stop at wrong count");
endmodule : ssp_checker

bind ssp_scan_control ssp_checker ssp_checker_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr),
	.regWrite(regWrite), .regWdata(regWdata), .streamEnable(streamEnable), .internalPaceTick(internalPaceTick),
	.edge_function_unit_edge(edge_function_unit_edge), .scanLaunch(scanLaunch), .streamArmed(streamArmed),
	.streamScanning(streamScanning), .burstFinished(burstFinished), .scansDone(scansDone));

`default_nettype wire

// >>> ssp_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// pulse source
// ----------------
module ssp_pulse_src (
	// clock and request
	input wire logic clk,
	input wire logic start,
	input wire logic [7:0] count,
	input wire logic [3:0] half,
	// pin
	output logic pin,
	output logic busy
);
	int n;

	// idles low between trains so no stray rising edge is seen
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (start) begin
				busy <= 1'b1;
				for (n = 0; n < count; n++) begin
					repeat (half) @(posedge clk);
					pin <= 1'b1;
					repeat (half) @(posedge clk);
					pin <= 1'b0;
				end
				@(posedge clk);
				busy <= 1'b0;
			end
		end
	end
endmodule : ssp_pulse_src

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// testbench
// ----------------
module tb
	import ssp_pkg::*;
;
	logic clk, nrst, regWrite, regRead, regRdValid, streamEnable, internalPaceTick, pin, pStart, pBusy;
	logic scanLaunch, streamArmed, streamScanning, burstFinished;
	logic [15:0] regAddr;
	logic [31:0] regWdata, regRdata, scansDone;
	logic [7:0] efEdge, pCount;
	logic [3:0] pHalf;
	int miscompares, tests_run, expCnt, burst, i, k;
	logic [31:0] launchQ[$], readQ[$];

	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	ssp_scan_control ssp_scan_control_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrite(regWrite),
		.regWdata(regWdata), .regRead(regRead), .regRdata(regRdata), .regRdValid(regRdValid),
		.streamEnable(streamEnable), .internalPaceTick(internalPaceTick), .external_pacing_input_pin(pin),
		.edge_function_unit_edge(efEdge), .scanLaunch(scanLaunch), .streamArmed(streamArmed),
		.streamScanning(streamScanning), .burstFinished(burstFinished), .scansDone(scansDone));
	ssp_pulse_src ssp_pulse_src_inst (.clk(clk), .start(pStart), .count(pCount), .half(pHalf), .pin(pin),
		.busy(pBusy));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		readQ.push_back(e);
		@(posedge clk);
		regRead <= 1'b0;
	endtask : rd

	// random ticks; when live is set, a launch is noted for each tick the burst still allows
	task automatic ticks(input int n, input bit live);
		repeat (n) begin
			@(posedge clk);
			k = $urandom % 2;
			internalPaceTick <= k[0];
			if (live && k == 1 && (burst == 0 || expCnt < burst)) begin
				expCnt++;
				launchQ.push_back(32'(expCnt));
			end
		end
		@(posedge clk);
		internalPaceTick <= 1'b0;
		@(negedge clk);
	endtask : ticks

	task automatic go(input logic [31:0] src, input logic [31:0] trig, input int b);
		wr(SSP_ADDR_PACING_SRC, src);
		wr(SSP_ADDR_TRIGGER_SEL, trig);
		wr(SSP_ADDR_BURST_COUNT, 32'(b));
		burst = b;
		expCnt = 0;
		@(posedge clk);
		streamEnable <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : go

	task automatic stop;
		@(posedge clk);
		streamEnable <= 1'b0;
		repeat (3) @(posedge clk);
		chk("pending launches", 32'h0, 32'(launchQ.size()));
	endtask : stop

	task automatic report_and_stop;
		chk("pending reads", 32'h0, 32'(readQ.size()));
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// each launch or read answer takes the oldest note
	always @(negedge clk) begin
		if (scanLaunch === 1'b1) begin
			if (launchQ.size() == 0) chk("stray launch", 32'h0, 32'h1);
			else chk("scansDone", launchQ.pop_front(), scansDone);
		end
		if (regRdValid === 1'b1) begin
			if (readQ.size() == 0) chk("stray read answer", 32'h0, 32'h1);
			else chk("regRdata", readQ.pop_front(), regRdata);
		end
	end

	// watchdog, generous against the expected run of a few hundred cycles
	initial begin
		#(50 * 20000);
		miscompares++;
		report_and_stop();
	end

	initial begin
		{nrst, regWrite, regRead, streamEnable, internalPaceTick, pStart} = 6'h0;
		{regAddr, regWdata, efEdge, pCount, pHalf} = 68'h0;
		i = $urandom(32'h0816);
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		rd(SSP_ADDR_PACING_SRC, SSP_RST_PACING_SRC);
		rd(SSP_ADDR_BURST_COUNT, SSP_RST_BURST_COUNT);
		rd(SSP_ADDR_EDGES_PER_SCAN, SSP_RST_EDGES_PER_SCAN);
		rd(SSP_ADDR_TRIGGER_SEL, SSP_RST_TRIGGER_SEL);
		wr(16'h0FB0, 32'h1234_5678);
		rd(16'h0FB0, 32'h0);
		wr(SSP_ADDR_BURST_COUNT, 32'hFFFF_FFFF);
		rd(SSP_ADDR_BURST_COUNT, 32'hFFFF_FFFF);
		// continuous, then a short burst
		for (i = 0; i < 2; i++) begin
			go(SSP_SRC_INTERNAL, SSP_TRIG_NONE, i * (1 + $urandom % 4));
			ticks(12, 1'b1);
			chk("burstFinished", 32'(burst != 0 && expCnt == burst), 32'(burstFinished));
			stop();
		end
		// reserved sources
		for (i = 1; i < 4; i += 2) begin
			go(32'(i), SSP_TRIG_NONE, 0);
			ticks(8, 1'b0);
			stop();
		end
		// divided external pacing, quick then slow pulses
		wr(SSP_ADDR_EDGES_PER_SCAN, 32'h3);
		for (i = 1; i < 3; i++) begin
			go(SSP_SRC_EXTERNAL, SSP_TRIG_NONE, 0);
			launchQ = {32'h1, 32'h2};
			pHalf <= 4'(i * 4 - 3);
			pCount <= 8'h7;
			pStart <= 1'b1;
			@(posedge clk);
			pStart <= 1'b0;
			repeat (3) @(posedge clk);
			for (k = 0; k < 300 && pBusy; k++) @(posedge clk);
			chk("pulse train done", 32'h0, 32'(pBusy));
			stop();
		end
		// every trigger code, a wrong unit first
		for (i = 0; i < 8; i++) begin
			go(SSP_SRC_INTERNAL, SSP_TRIG_UNIT_BASE + 32'(i), 0);
			@(posedge clk);
			efEdge <= 8'(1 << ((i + 1) % 8));
			@(posedge clk);
			efEdge <= 8'(1 << i);
			@(posedge clk);
			efEdge <= 8'h0;
			ticks(4, SSP_TRIG_UNIT_MASK[i]);
			chk("streamArmed", 32'(!SSP_TRIG_UNIT_MASK[i]), 32'(streamArmed));
			stop();
		end
		report_and_stop();
	end
endmodule : tb

`default_nettype wire
